//--- pbr_regs.sv
// supervisor, spare_storage_bits and step-down converter control register bank
// assumes a serial host front end that hands over byte writes and read strobes,
// analog status levels synchronous to clock, and rst driven by supply undervoltage
`timescale 1ns/1ns

module pbr_regs (
  // clock and undervoltage reset
  input wire logic clock,
  input wire logic rst,
  // host byte access
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic rvalid,
  // analog status inputs
  input wire logic supply_below_threshold,
  input wire logic b1_fault,
  input wire logic b1_power_good,
  input wire logic b2_fault,
  input wire logic b2_power_good,
  input wire logic voltage_set_selector_pin,
  input wire logic reset_request,
  // controls to the analog blocks
  output logic [3:0] supply_detect_threshold,
  output logic low_supply_irq,
  output logic system_shutdown,
  output logic reset_output_pin_n,
  output logic [5:0] b1_voltage_code,
  output logic b1_enable,
  output logic b1_phase_shift,
  output logic b1_forced_pwm,
  output logic [2:0] b1_turn_on_delay,
  output logic b1_fault_irq,
  output logic [5:0] b2_voltage_code
);
  localparam int TW = 25;

  // stored fields
  logic trst_r, trst_nxt;
  logic resp_r, resp_nxt;
  logic unmask_r, unmask_nxt;
  logic [3:0] thr_r, thr_nxt;
  logic [3:0] spare_storage_bits_r, spare_storage_bits_nxt;
  logic [5:0] b1_pri_r, b1_pri_nxt;
  logic [5:0] b1_sec_r, b1_sec_nxt;
  logic [5:0] b2_pri_r, b2_pri_nxt;
  logic [5:0] b2_sec_r, b2_sec_nxt;
  logic [7:1] b1_ctl_r, b1_ctl_nxt;
  // output flops
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic irq_r, irq_nxt;
  logic shdn_r, shdn_nxt;
  logic [5:0] b1_v_r, b1_v_nxt;
  logic [5:0] b2_v_r, b2_v_nxt;
  logic flt_r, flt_nxt;
  logic rsto_r, rsto_nxt;
  logic rel;
  logic [TW-1:0] tmo;

  // voltage registers store six bits; the reserved top pair reads back as zero
  function automatic logic [7:0] volt_readback(input logic [5:0] code);
    volt_readback = {2'h0, code};
  endfunction : volt_readback

  // the selector pin picks one of the two stored codes of a converter
  function automatic logic [5:0] pick_set(input logic sel, input logic [5:0] pri,
    input logic [5:0] sec);
    pick_set = sel ? sec : pri;
  endfunction : pick_set

  // a write lands only on an exact byte address; unmapped writes are dropped
  function automatic logic wr_hit(input logic en, input logic [7:0] a,
    input logic [7:0] target);
    wr_hit = en && (a == target);
  endfunction : wr_hit

  // supervisor group: time-out, response, unmask and threshold share one byte
  always_comb begin
    trst_nxt = trst_r;
    resp_nxt = resp_r;
    unmask_nxt = unmask_r;
    thr_nxt = thr_r;
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_SUPERVISOR)) begin
      trst_nxt = wdata[pbr_pkg::SUP_TRST_BIT];
      resp_nxt = wdata[pbr_pkg::SUP_RESP_BIT];
      unmask_nxt = wdata[pbr_pkg::SUP_UNMASK_BIT];
      thr_nxt = wdata[3:0];
    end
  end

  // supervisor registers; bit 4 is live status, so no flop stands behind it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      trst_r <= pbr_pkg::RST_SUPERVISOR[pbr_pkg::SUP_TRST_BIT];
      resp_r <= pbr_pkg::RST_SUPERVISOR[pbr_pkg::SUP_RESP_BIT];
      unmask_r <= pbr_pkg::RST_SUPERVISOR[pbr_pkg::SUP_UNMASK_BIT]; // masked by default
      thr_r <= pbr_pkg::RST_SUPERVISOR[3:0];
    end else begin
      trst_r <= trst_nxt;
      resp_r <= resp_nxt;
      unmask_r <= unmask_nxt;
      thr_r <= thr_nxt;
    end
  end

  // spare_storage_bits group: only the low nibble is stored, the upper nibble reads zero
  always_comb begin
    spare_storage_bits_nxt = spare_storage_bits_r;
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_SPARE_STORAGE_BITS)) begin
      spare_storage_bits_nxt = wdata[3:0];
    end
  end

  // spare_storage_bits register; volatile, so every undervoltage wipes it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spare_storage_bits_r <= pbr_pkg::RST_SPARE_STORAGE_BITS;
    end else begin
      spare_storage_bits_r <= spare_storage_bits_nxt;
    end
  end

  // voltage code group for both converters; the top two bits are never stored
  always_comb begin
    b1_pri_nxt = b1_pri_r;
    b1_sec_nxt = b1_sec_r;
    b2_pri_nxt = b2_pri_r;
    b2_sec_nxt = b2_sec_r;
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_B1_VPRI)) begin
      b1_pri_nxt = wdata[5:0];
    end
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_B1_VSEC)) begin
      b1_sec_nxt = wdata[5:0];
    end
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_B2_VPRI)) begin
      b2_pri_nxt = wdata[5:0];
    end
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_B2_VSEC)) begin
      b2_sec_nxt = wdata[5:0];
    end
  end

  // voltage code registers; both sets of a converter start at the same default
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      b1_pri_r <= pbr_pkg::RST_B1_VOLT;
      b1_sec_r <= pbr_pkg::RST_B1_VOLT;
      b2_pri_r <= pbr_pkg::RST_B2_VOLT;
      b2_sec_r <= pbr_pkg::RST_B2_VOLT;
    end else begin
      b1_pri_r <= b1_pri_nxt;
      b1_sec_r <= b1_sec_nxt;
      b2_pri_r <= b2_pri_nxt;
      b2_sec_r <= b2_sec_nxt;
    end
  end

  // converter control group; bit 0 is live power-good and is not stored
  always_comb begin
    b1_ctl_nxt = b1_ctl_r;
    if (wr_hit(wr_en, addr, pbr_pkg::ADDR_B1_CTRL)) begin
      b1_ctl_nxt = wdata[7:1];
    end
  end

  // converter control register; off and in phase after undervoltage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      b1_ctl_r <= pbr_pkg::RST_CTRL[7:1];
    end else begin
      b1_ctl_r <= b1_ctl_nxt;
    end
  end

  // time-out selection; the counter restarts on every reset request
  assign tmo = trst_r ? TW'(pbr_pkg::TRST_SHORT_CYC) : TW'(pbr_pkg::TRST_LONG_CYC);

  pbr_rst_timer #(
    .W(TW)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .hold(reset_request),
    .limit(tmo),
    .released(rel)
  );

  // read answer group: rdata holds until the next strobe, so a late host still
  // sees the byte it asked for; reserved and unmapped bits read zero
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = rd_en; // exactly one cycle after the strobe
    if (rd_en) begin
      unique case (addr)
        pbr_pkg::ADDR_SUPERVISOR: begin
          rdata_nxt = {trst_r, resp_r, unmask_r, supply_below_threshold, thr_r};
        end
        pbr_pkg::ADDR_SPARE_STORAGE_BITS: rdata_nxt = {4'h0, spare_storage_bits_r};
        pbr_pkg::ADDR_B1_VPRI: rdata_nxt = volt_readback(b1_pri_r);
        pbr_pkg::ADDR_B1_VSEC: rdata_nxt = volt_readback(b1_sec_r);
        pbr_pkg::ADDR_B1_CTRL: rdata_nxt = {b1_ctl_r, b1_power_good};
        pbr_pkg::ADDR_B2_VPRI: rdata_nxt = volt_readback(b2_pri_r);
        pbr_pkg::ADDR_B2_VSEC: rdata_nxt = volt_readback(b2_sec_r);
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // read answer registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // low supply group: both responses are levels that follow the detector, so the
  // host clears the cause, not a flag
  always_comb begin
    irq_nxt = supply_below_threshold && resp_r && unmask_r;
    shdn_nxt = supply_below_threshold && !resp_r;
  end

  // low supply registers; cleared so no false shutdown follows power-up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
      shdn_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
      shdn_r <= shdn_nxt;
    end
  end

  // converter group: the selector pin is taken as synchronous, so one flop stage
  // is enough; an asynchronous pin would need a synchroniser in front
  always_comb begin
    b1_v_nxt = pick_set(voltage_set_selector_pin, b1_pri_r, b1_sec_r);
    b2_v_nxt = pick_set(voltage_set_selector_pin, b2_pri_r, b2_sec_r);
    flt_nxt = b1_fault && b1_ctl_r[pbr_pkg::CTL_FLT_BIT];
  end

  // converter output registers; codes start at the stored defaults
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      b1_v_r <= pbr_pkg::RST_B1_VOLT;
      b2_v_r <= pbr_pkg::RST_B2_VOLT;
      flt_r <= 1'b0;
    end else begin
      b1_v_r <= b1_v_nxt;
      b2_v_r <= b2_v_nxt;
      flt_r <= flt_nxt;
    end
  end

  // reset output group: the pin stays low until the timer has run out
  always_comb begin
    rsto_nxt = rel;
  end

  // reset output register; low during undervoltage so the host is held in reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsto_r <= 1'b0;
    end else begin
      rsto_r <= rsto_nxt;
    end
  end

  // outputs; control bits come straight from their stored flops
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign supply_detect_threshold = thr_r;
  assign low_supply_irq = irq_r;
  assign system_shutdown = shdn_r;
  assign reset_output_pin_n = rsto_r;
  assign b1_voltage_code = b1_v_r;
  assign b1_enable = b1_ctl_r[pbr_pkg::CTL_ON_BIT];
  assign b1_phase_shift = b1_ctl_r[pbr_pkg::CTL_PHASE_BIT];
  assign b1_forced_pwm = b1_ctl_r[pbr_pkg::CTL_MODE_BIT];
  assign b1_turn_on_delay = b1_ctl_r[pbr_pkg::CTL_DLY_HI:pbr_pkg::CTL_DLY_LO];
  assign b1_fault_irq = flt_r;
  assign b2_voltage_code = b2_v_r;
endmodule : pbr_regs

//--- pbr_pkg.sv
// package for the supervisor and step-down converter control register bank
// assumes byte-wide registers reached by 8-bit byte address from a serial host front end
package pbr_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_SUPERVISOR = 8'h00;
  localparam logic [7:0] ADDR_SPARE_STORAGE_BITS = 8'h01;
  localparam logic [7:0] ADDR_B1_VPRI = 8'h20;
  localparam logic [7:0] ADDR_B1_VSEC = 8'h21;
  localparam logic [7:0] ADDR_B1_CTRL = 8'h22;
  localparam logic [7:0] ADDR_B2_VPRI = 8'h30;
  localparam logic [7:0] ADDR_B2_VSEC = 8'h31;
  // supervisor register field positions
  localparam int SUP_TRST_BIT = 7;
  localparam int SUP_RESP_BIT = 6;
  localparam int SUP_UNMASK_BIT = 5;
  localparam int SUP_STAT_BIT = 4;
  // converter control register field positions
  localparam int CTL_ON_BIT = 7;
  localparam int CTL_PHASE_BIT = 6;
  localparam int CTL_MODE_BIT = 5;
  localparam int CTL_DLY_HI = 4;
  localparam int CTL_DLY_LO = 2;
  localparam int CTL_FLT_BIT = 1;
  localparam int CTL_OK_BIT = 0;
  // values after reset
  localparam logic [7:0] RST_SUPERVISOR = 8'h00;
  localparam logic [3:0] RST_SPARE_STORAGE_BITS = 4'h0;
  localparam logic [5:0] RST_B1_VOLT = 6'h39;
  localparam logic [5:0] RST_B2_VOLT = 6'h1a;
  localparam logic [7:0] RST_CTRL = 8'h00;
  // reset output time-outs
  localparam longint CLK_HZ = 125_000_000;
  localparam longint TRST_SHORT_MS = 65;
  localparam longint TRST_LONG_MS = 260;
  localparam longint TRST_SHORT_CYC = TRST_SHORT_MS * CLK_HZ / 1000;
  localparam longint TRST_LONG_CYC = TRST_LONG_MS * CLK_HZ / 1000;
endpackage : pbr_pkg

//--- pbr_rst_timer.sv
// reset output time-out counter for the supervisor register bank
// assumes one clock; counts restart whenever the hold request is high
`timescale 1ns/1ns
module pbr_rst_timer #(
  parameter int W = 25
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic hold,
  input wire logic [W-1:0] limit,
  // status
  output logic released
);
  logic [W-1:0] cnt_r, cnt_nxt;
  logic rel_r, rel_nxt;

  // count up while not held; release once the limit is reached
  always_comb begin
    cnt_nxt = cnt_r;
    rel_nxt = rel_r;
    if (hold) begin
      cnt_nxt = '0;
      rel_nxt = 1'b0;
    end else if (!rel_r) begin
      if (cnt_r + W'(1) >= limit) begin
        rel_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  // register stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      rel_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      rel_r <= rel_nxt;
    end
  end

  assign released = rel_r;
endmodule : pbr_rst_timer

//--- pbr_regs_properties.sv
// assertion checker for the supervisor and converter register bank
// assumes it is bound to pbr_regs; one clock, rst async active high
`timescale 1ns/1ns
module pbr_regs_properties (
  // clock and reset
  input wire logic clock, rst,
  // host access
  input wire logic rd_en, rvalid,
  input wire logic [7:0] addr, rdata,
  // status and controls
  input wire logic supply_below_threshold, b1_fault, b1_power_good, reset_request,
  input wire logic [3:0] supply_detect_threshold,
  input wire logic low_supply_irq, system_shutdown, reset_output_pin_n, b1_fault_irq
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // read path: answer latency, unmapped and reserved bits
  property p_rvalid; rd_en |=> rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read answer late");
  property p_unmap; rd_en && !(addr inside {8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31})
    |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_vres; rd_en && addr[3:1] == 3'b000 && addr[7:5] == 3'b001 |=> rdata[7:6] == 2'b00;
  endproperty
  a_vres: assert property (p_vres) else $error("voltage reserved bits set");
  // status bits read live and threshold read back at the strobe edge
  property p_stat; rd_en && addr == 8'h00 |=> rdata[4] == $past(supply_below_threshold); endproperty
  a_stat: assert property (p_stat) else $error("supply status wrong");
  property p_thr; rd_en && addr == 8'h00 |=> rdata[3:0] == $past(supply_detect_threshold);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold readback wrong");
  property p_pg; rd_en && addr == 8'h22 |=> rdata[0] == $past(b1_power_good); endproperty
  a_pg: assert property (p_pg) else $error("power good readback wrong");
  // responses need a low supply and never both at once
  property p_resp; (low_supply_irq || system_shutdown) |-> $past(supply_below_threshold) &&
    !(low_supply_irq && system_shutdown); endproperty
  a_resp: assert property (p_resp) else $error("low supply response wrong");
  property p_fault; b1_fault_irq |-> $past(b1_fault); endproperty
  a_fault: assert property (p_fault) else $error("fault irq without fault");
  property p_rsto; reset_request [*3] |-> !reset_output_pin_n; endproperty
  a_rsto: assert property (p_rsto) else $error("reset output released early");
endmodule : pbr_regs_properties

bind pbr_regs pbr_regs_properties u_pbr_props (.clock(clock), .rst(rst), .rd_en(rd_en),
  .rvalid(rvalid), .addr(addr), .rdata(rdata), .supply_below_threshold(supply_below_threshold),
  .b1_fault(b1_fault), .b1_power_good(b1_power_good), .reset_request(reset_request),
  .supply_detect_threshold(supply_detect_threshold), .low_supply_irq(low_supply_irq),
  .system_shutdown(system_shutdown), .reset_output_pin_n(reset_output_pin_n),
  .b1_fault_irq(b1_fault_irq));

//--- pbr_regs_tb.sv
// self-checking bench for the register bank
// assumes pbr_pkg and pbr_regs compiled first; inputs move at falling edges
`timescale 1ns/1ns
module pbr_regs_tb;
  logic clock, rst, wr_en, rd_en, rvalid, b1_fault, b1_power_good, b2_fault, b2_power_good;
  logic supply_below_threshold, voltage_set_selector_pin, reset_request, low_supply_irq;
  logic system_shutdown, reset_output_pin_n, b1_enable, b1_phase_shift, b1_forced_pwm;
  logic b1_fault_irq;
  logic [7:0] addr, wdata, rdata, got;
  logic [3:0] supply_detect_threshold;
  logic [5:0] b1_voltage_code, b2_voltage_code;
  logic [2:0] b1_turn_on_delay;
  logic [7:0] ad [8], dflt [8], msk [8], cv [2];
  int errors, checked;
  pbr_regs dut (.clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .supply_below_threshold(supply_below_threshold),
    .b1_fault(b1_fault), .b1_power_good(b1_power_good), .b2_fault(b2_fault),
    .b2_power_good(b2_power_good), .voltage_set_selector_pin(voltage_set_selector_pin),
    .reset_request(reset_request), .supply_detect_threshold(supply_detect_threshold),
    .low_supply_irq(low_supply_irq), .system_shutdown(system_shutdown),
    .reset_output_pin_n(reset_output_pin_n), .b1_voltage_code(b1_voltage_code),
    .b1_enable(b1_enable), .b1_phase_shift(b1_phase_shift), .b1_forced_pwm(b1_forced_pwm),
    .b1_turn_on_delay(b1_turn_on_delay), .b1_fault_irq(b1_fault_irq),
    .b2_voltage_code(b2_voltage_code));
  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // result checks and verdict
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic complete_run;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // host byte access, one strobe cycle per call
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clock);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    {rd_en, addr} = {1'b1, a};
    @(negedge clock);
    rd_en = 1'b0;
    chk({7'h0, rvalid}, 8'h01);
    got = rdata;
  endtask : rd
  // hang guard, far beyond the hundred or so cycles needed
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    ad = '{8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h30, 8'h31, 8'h32};
    dflt = '{pbr_pkg::RST_SUPERVISOR, {4'h0, pbr_pkg::RST_SPARE_STORAGE_BITS}, {2'b00, pbr_pkg::RST_B1_VOLT},
      {2'b00, pbr_pkg::RST_B1_VOLT}, pbr_pkg::RST_CTRL, {2'b00, pbr_pkg::RST_B2_VOLT},
      {2'b00, pbr_pkg::RST_B2_VOLT}, 8'h00};
    msk = '{8'hef, 8'h0f, 8'h3f, 8'h3f, 8'hfe, 8'h3f, 8'h3f, 8'h00};
    cv = '{8'hb4, 8'h4a};
    {wr_en, rd_en, supply_below_threshold, b1_fault, b1_power_good, b2_fault} = '0;
    {b2_power_good, voltage_set_selector_pin, reset_request, addr, wdata} = '0;
    {errors, checked, rst} = {32'h0000_0000, 32'h0000_0000, 1'b1};
    repeat (6) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chk({7'h0, reset_output_pin_n}, 8'h00);
    // defaults, then all ones: only writable bits stick
    foreach (ad[i]) begin
      rd(ad[i]);
      chk(got, dflt[i]);
      wr(ad[i], 8'hff);
      rd(ad[i]);
      chk(got, msk[i]);
    end
    // converter control fields in both polarities
    foreach (cv[i]) begin
      wr(8'h22, cv[i]);
      chk({b1_enable, b1_phase_shift, b1_forced_pwm, b1_turn_on_delay, 2'b00},
        cv[i] & 8'hfc);
    end
    b1_fault = 1'b1;
    tick(1);
    chk({7'h0, b1_fault_irq}, 8'h01);
    wr(8'h22, 8'h48);
    tick(1);
    chk({7'h0, b1_fault_irq}, 8'h00);
    b1_power_good = 1'b1;
    rd(8'h22);
    chk(got, 8'h49);
    // voltage set follows the selector pin
    wr(8'h20, 8'h05);
    wr(8'h21, 8'h2a);
    wr(8'h30, 8'h11);
    wr(8'h31, 8'h22);
    tick(1);
    chk({b1_voltage_code, b2_voltage_code[5:4]}, {6'h05, 2'b01});
    chk({2'b00, b2_voltage_code}, 8'h11);
    voltage_set_selector_pin = 1'b1;
    tick(1);
    chk({b1_voltage_code, b2_voltage_code[5:4]}, {6'h2a, 2'b10});
    chk({2'b00, b2_voltage_code}, 8'h22);
    // low supply: masked, then interrupt, then shutdown
    wr(8'h00, 8'h47);
    supply_below_threshold = 1'b1;
    tick(1);
    chk({6'h0, low_supply_irq, system_shutdown}, 8'h00);
    chk({4'h0, supply_detect_threshold}, 8'h07);
    rd(8'h00);
    chk(got, 8'h57);
    wr(8'h00, 8'h67);
    tick(1);
    chk({6'h0, low_supply_irq, system_shutdown}, 8'h02);
    wr(8'h00, 8'h27);
    tick(1);
    chk({6'h0, low_supply_irq, system_shutdown}, 8'h01);
    supply_below_threshold = 1'b0;
    reset_request = 1'b1;
    tick(2);
    chk({7'h0, reset_output_pin_n}, 8'h00);
    // undervoltage in mid-run clears stored bits
    wr(8'h01, 8'h0a);
    rst = 1'b1;
    tick(1);
    rst = 1'b0;
    rd(8'h01);
    chk(got, 8'h00);
    rd(8'h22);
    chk(got, 8'h01);
    complete_run();
  end
endmodule : pbr_regs_tb
